/* logic/unbalanced_load_map.svh */
`ifndef UNBALANCED_LOAD_MAP_SVH
`define UNBALANCED_LOAD_MAP_SVH

// Current magnitudes are unsigned fixed point, 16 bits, 1/256 of nominal per LSB.
`define UL_CUR_W 16
`define UL_TIME_W 24
`define UL_ACC_W 32
// Validity window: 0.05 x nominal is 12.8 LSB (rounded up to 13), 10 x nominal is 2560 LSB.
`define UL_MIN_VALID 16'h000D
`define UL_MAX_VALID 16'h0A00
// Ratios in 1/256 units: 1.1 -> 282, 0.95 -> 243, 0.90 -> 230.
`define UL_PU_RATIO 16'h011A
`define UL_DO_RATIO 16'h00F3
`define UL_RST_RATIO 16'h00E6
// All-ones in a threshold, delay or multiplier field stands for infinity.
`define UL_INF_CUR 16'hFFFF
`define UL_INF_TIME 24'hFF_FFFF
`define UL_INF_MULT 16'hFFFF
// Zero value of accumulator width, loaded on curve accumulator resets.
`define UL_ACC_ZERO 32'h0000_0000

`endif

/* logic/unbalanced_load_pkg.sv */
package unbalanced_load_pkg;

    typedef enum logic [1:0] {
        CURVE_IEC = 2'b00,
        CURVE_ANSI = 2'b01
    } curve_t;

    typedef enum logic [1:0] {
        DT_IDLE = 2'b00,
        DT_RUN = 2'b01,
        DT_HOLD = 2'b11,
        DT_DONE = 2'b10
    } dt_state_t;

endpackage

/* logic/definite_stage.sv */
`timescale 1ns/1ps
`default_nettype none
`include "unbalanced_load_map.svh"

// One definite-time stage with pickup hold (dropout stabilisation).
module definite_stage (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic enable,
    input wire logic [`UL_CUR_W-1:0] negSeq,
    input wire logic [`UL_CUR_W-1:0] threshold,
    input wire logic [`UL_TIME_W-1:0] tripDelay,
    input wire logic [`UL_TIME_W-1:0] holdTime,
    output logic pickup,
    output logic trip
);
    unbalanced_load_pkg::dt_state_t state_q;
    unbalanced_load_pkg::dt_state_t state_d;
    logic [`UL_TIME_W-1:0] delayCnt_q;
    logic [`UL_TIME_W-1:0] delayCnt_d;
    logic [`UL_TIME_W-1:0] holdCnt_q;
    logic [`UL_TIME_W-1:0] holdCnt_d;
    logic trip_q;
    logic trip_d;

    wire logic over = (threshold != `UL_INF_CUR) && (negSeq >= threshold);
    wire logic delayInf = (tripDelay == `UL_INF_TIME);
    wire logic delayDone = !delayInf && (delayCnt_q >= tripDelay);
    wire logic holdDone = (holdCnt_q >= holdTime);
    wire logic [`UL_TIME_W-1:0] delayInc = (delayCnt_q == `UL_INF_TIME) ? delayCnt_q : delayCnt_q + 1'b1;

    always_comb begin
        state_d = state_q;
        delayCnt_d = delayCnt_q;
        holdCnt_d = holdCnt_q;
        trip_d = trip_q;
        if (!enable) begin
            state_d = unbalanced_load_pkg::DT_IDLE;
            delayCnt_d = '0;
            holdCnt_d = '0;
            trip_d = 1'b0;
        end else if (tick) begin
            case (state_q)
                unbalanced_load_pkg::DT_IDLE: begin
                    if (over) begin
                        state_d = unbalanced_load_pkg::DT_RUN;
                        delayCnt_d = `UL_TIME_W'(1);
                    end
                end
                unbalanced_load_pkg::DT_RUN: begin
                    delayCnt_d = delayInc;
                    if (over && delayDone) begin
                        trip_d = 1'b1;
                    end
                    if (!over) begin
                        state_d = unbalanced_load_pkg::DT_HOLD;
                        holdCnt_d = `UL_TIME_W'(1);
                    end
                end
                unbalanced_load_pkg::DT_HOLD: begin
                    delayCnt_d = delayInc;
                    holdCnt_d = holdCnt_q + 1'b1;
                    if (over) begin
                        state_d = unbalanced_load_pkg::DT_RUN;
                        holdCnt_d = '0;
                        if (delayDone) begin
                            trip_d = 1'b1;
                        end
                    end else if (holdDone) begin
                        state_d = unbalanced_load_pkg::DT_IDLE;
                        delayCnt_d = '0;
                        holdCnt_d = '0;
                        trip_d = 1'b0;
                    end
                end
                default: begin
                    state_d = unbalanced_load_pkg::DT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= unbalanced_load_pkg::DT_IDLE;
            delayCnt_q <= '0;
            holdCnt_q <= '0;
            trip_q <= 1'b0;
        end else begin
            state_q <= state_d;
            delayCnt_q <= delayCnt_d;
            holdCnt_q <= holdCnt_d;
            trip_q <= trip_d;
        end
    end

    assign pickup = (state_q == unbalanced_load_pkg::DT_RUN) || (state_q == unbalanced_load_pkg::DT_HOLD);
    assign trip = trip_q;
endmodule

`default_nettype wire

/* logic/unbalanced_load_trip_logic.sv */
// Behaviour
// - Function active only if some phase above 0.05 In and all below 10 In.
// - Losing phase-current validity resets all pickups of the function.
// - Stage-one threshold reached asserts stage-one pickup and starts its delay.
// - Stage-two threshold reached asserts stage-two pickup and starts its delay.
// - Either definite delay expiring issues the trip output.
// - Inverse stage picks up only above 1.1 times its threshold.
// - Inverse trip time follows present current via the curve; trip when reached.
// - IEC curve: drop out near 95 percent, timer resets at once.
// - ANSI curve: choose instantaneous or disk dropout; instantaneous restarts from zero.
// - Disk mode: below 90 percent the accumulator decrements per reset curve.
// - Disk mode: between 90 and 95 percent the accumulator holds.
// - Blocking input resets pickups, timers and stored measured value.
// - Definite stage below threshold starts hold timer, pickup and delay continue.
// - Hold expiry without re-exceeding drops pickup and resets trip delay.
// - Re-exceeding during hold cancels hold; trip delay continues.
// - Delay expired during hold trips once threshold exceeded before hold ends.
// - Hold time never affects inverse-stage trip timing.
// - Definite stages stay active alongside the inverse stage.
// - Infinite inverse time multiplier: pickup signalled, never trips.
`timescale 1ns/1ps
`default_nettype none
`include "unbalanced_load_map.svh"

module unbalanced_load_trip_logic (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic blockIn,
    input wire logic [`UL_CUR_W-1:0] phaseA,
    input wire logic [`UL_CUR_W-1:0] phaseB,
    input wire logic [`UL_CUR_W-1:0] phaseC,
    input wire logic [`UL_CUR_W-1:0] negSeq,
    input wire logic [`UL_CUR_W-1:0] stage1Threshold,
    input wire logic [`UL_TIME_W-1:0] stage1Delay,
    input wire logic [`UL_CUR_W-1:0] stage2Threshold,
    input wire logic [`UL_TIME_W-1:0] stage2Delay,
    input wire logic [`UL_TIME_W-1:0] holdTime,
    input wire logic inverseEnable,
    input wire unbalanced_load_pkg::curve_t curveType,
    input wire logic diskEmulation,
    input wire logic [`UL_CUR_W-1:0] inverse_stage_threshold,
    input wire logic [`UL_CUR_W-1:0] inverse_time_multiplier,
    input wire logic [`UL_ACC_W-1:0] curveTripLevel,
    input wire logic [`UL_ACC_W-1:0] curveRate,
    input wire logic [`UL_ACC_W-1:0] curveResetRate,
    output logic functionActive,
    output logic stage1Pickup,
    output logic stage2Pickup,
    output logic inversePickup,
    output logic stage1Trip,
    output logic stage2Trip,
    output logic inverseTrip,
    output logic tripOut,
    output logic [`UL_CUR_W-1:0] storedNegSeq,
    output logic [`UL_ACC_W-1:0] inverseAccum
);
    // The curve evaluation (rate per tick and trip level) is done outside.
    // This block only integrates the supplied rates, which keeps the divider
    // and power functions out of the fast logic at the cost of a wider port.

    function automatic logic [`UL_CUR_W+15:0] scaleRatio(
        input logic [`UL_CUR_W-1:0] level,
        input logic [15:0] ratio
    );
        scaleRatio = level * ratio;
    endfunction

    function automatic logic [`UL_CUR_W+15:0] upScale(input logic [`UL_CUR_W-1:0] cur);
        upScale = {cur, 8'h00} + (`UL_CUR_W+16)'(0);
    endfunction

    logic tick_q;
    logic [`UL_CUR_W-1:0] negSeq_q;
    logic [`UL_CUR_W-1:0] phaseA_q;
    logic [`UL_CUR_W-1:0] phaseB_q;
    logic [`UL_CUR_W-1:0] phaseC_q;
    logic inversePickup_q;
    logic inversePickup_d;
    logic [`UL_ACC_W-1:0] accum_q;
    logic [`UL_ACC_W-1:0] accum_d;
    logic inverseTrip_q;
    logic inverseTrip_d;
    logic tripOut_q;
    logic [`UL_CUR_W-1:0] stored_q;

    // Measured values are sampled on the tick so every comparison sees one set.
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_q <= 1'b0;
            negSeq_q <= '0;
            phaseA_q <= '0;
            phaseB_q <= '0;
            phaseC_q <= '0;
        end else begin
            tick_q <= tick;
            if (tick) begin
                negSeq_q <= negSeq;
                phaseA_q <= phaseA;
                phaseB_q <= phaseB;
                phaseC_q <= phaseC;
            end
        end
    end

    wire logic anyAbove = (phaseA_q > `UL_MIN_VALID) || (phaseB_q > `UL_MIN_VALID) ||
        (phaseC_q > `UL_MIN_VALID);
    wire logic allBelow = (phaseA_q < `UL_MAX_VALID) && (phaseB_q < `UL_MAX_VALID) &&
        (phaseC_q < `UL_MAX_VALID);
    wire logic valid = anyAbove && allBelow;
    wire logic stageEnable = valid && !blockIn;

    definite_stage u_stage1 (
        .clk(clk),
        .rst(rst),
        .tick(tick_q),
        .enable(stageEnable),
        .negSeq(negSeq_q),
        .threshold(stage1Threshold),
        .tripDelay(stage1Delay),
        .holdTime(holdTime),
        .pickup(stage1Pickup),
        .trip(stage1Trip)
    );

    definite_stage u_stage2 (
        .clk(clk),
        .rst(rst),
        .tick(tick_q),
        .enable(stageEnable),
        .negSeq(negSeq_q),
        .threshold(stage2Threshold),
        .tripDelay(stage2Delay),
        .holdTime(holdTime),
        .pickup(stage2Pickup),
        .trip(stage2Trip)
    );

    wire logic invThrInf = (inverse_stage_threshold == `UL_INF_CUR);
    wire logic [`UL_CUR_W+15:0] curScaled = upScale(negSeq_q);
    wire logic aboveStart = !invThrInf && (curScaled > scaleRatio(inverse_stage_threshold, `UL_PU_RATIO));
    wire logic belowDrop = invThrInf || (curScaled <= scaleRatio(inverse_stage_threshold, `UL_DO_RATIO));
    wire logic belowReset = invThrInf || (curScaled <= scaleRatio(inverse_stage_threshold, `UL_RST_RATIO));
    wire logic useDisk = (curveType == unbalanced_load_pkg::CURVE_ANSI) && diskEmulation;
    wire logic multInf = (inverse_time_multiplier == `UL_INF_MULT);
    wire logic [`UL_ACC_W:0] accSum = {1'b0, accum_q} + {1'b0, curveRate};
    wire logic [`UL_ACC_W-1:0] accUp = accSum[`UL_ACC_W] ? {`UL_ACC_W{1'b1}} : accSum[`UL_ACC_W-1:0];
    wire logic [`UL_ACC_W-1:0] accDown = (accum_q > curveResetRate) ? accum_q - curveResetRate : `UL_ACC_ZERO;

    always_comb begin
        inversePickup_d = inversePickup_q;
        accum_d = accum_q;
        inverseTrip_d = inverseTrip_q;
        if (!stageEnable || !inverseEnable) begin
            inversePickup_d = 1'b0;
            accum_d = `UL_ACC_ZERO;
            inverseTrip_d = 1'b0;
        end else if (tick_q) begin
            if (aboveStart) begin
                inversePickup_d = 1'b1;
            end else if (belowDrop) begin
                inversePickup_d = 1'b0;
            end
            if (aboveStart || (inversePickup_q && !belowDrop)) begin
                accum_d = accUp;
            end else if (!useDisk) begin
                accum_d = `UL_ACC_ZERO;
            end else if (belowReset) begin
                accum_d = accDown;
            end else begin
                accum_d = accum_q;
            end
            inverseTrip_d = inversePickup_d && !multInf && (accum_d >= curveTripLevel);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            inversePickup_q <= 1'b0;
            accum_q <= `UL_ACC_ZERO;
            inverseTrip_q <= 1'b0;
            tripOut_q <= 1'b0;
            stored_q <= '0;
        end else begin
            inversePickup_q <= inversePickup_d;
            accum_q <= accum_d;
            inverseTrip_q <= inverseTrip_d;
            tripOut_q <= stage1Trip || stage2Trip || inverseTrip_q;
            if (blockIn) begin
                stored_q <= '0;
            end else if (tick_q && (stage1Pickup || stage2Pickup || inversePickup_q)) begin
                stored_q <= negSeq_q;
            end
        end
    end

    assign functionActive = stageEnable;
    assign inversePickup = inversePickup_q;
    assign inverseTrip = inverseTrip_q;
    assign tripOut = tripOut_q;
    assign storedNegSeq = stored_q;
    assign inverseAccum = accum_q;
endmodule

`default_nettype wire

/* tb/ul_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "unbalanced_load_map.svh"
module ul_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic blockIn,
    input wire unbalanced_load_pkg::curve_t curveType,
    input wire logic [`UL_TIME_W-1:0] stage1Delay,
    input wire logic [`UL_CUR_W-1:0] inverse_time_multiplier,
    input wire logic functionActive,
    input wire logic stage1Pickup,
    input wire logic stage2Pickup,
    input wire logic inversePickup,
    input wire logic stage1Trip,
    input wire logic stage2Trip,
    input wire logic inverseTrip,
    input wire logic tripOut,
    input wire logic [`UL_CUR_W-1:0] storedNegSeq,
    input wire logic [`UL_ACC_W-1:0] inverseAccum
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire logic anyPu = stage1Pickup | stage2Pickup | inversePickup;
    wire logic anyTrip = stage1Trip | stage2Trip | inverseTrip;
    sequence blockHeld;
        blockIn [*4];
    endsequence
    sequence idleIec;
        (curveType == unbalanced_load_pkg::CURVE_IEC && !inversePickup) [*3];
    endsequence
    AST_BLOCK_CLEARS: assert property (blockHeld |-> !anyPu && !tripOut && storedNegSeq == '0)
        else $error("Block left a pickup, trip or stored value.");
    AST_INVALID_DROPS: assert property ((!functionActive) [*4] |-> !anyPu)
        else $error("Pickup held while the function is inactive.");
    AST_TICK_PACED: assert property ($rose(stage1Pickup) |-> $past(tick) || $past(tick, 2) || $past(tick, 3))
        else $error("Stage one picked up without a tick.");
    AST_TRIP_OUT_SET: assert property ($rose(anyTrip) && !blockIn |=> tripOut)
        else $error("Stage trip did not reach the trip output.");
    AST_TRIP_OUT_CAUSE: assert property (!anyTrip |=> !tripOut)
        else $error("Trip output without any stage trip.");
    AST_TRIP_NEEDS_PU: assert property (stage1Trip |-> stage1Pickup)
        else $error("Stage one trip without pickup.");
    AST_INF_DELAY: assert property (stage1Delay == `UL_INF_TIME |-> !stage1Trip)
        else $error("Infinite delay still tripped.");
    AST_INF_MULT: assert property (inverse_time_multiplier == `UL_INF_MULT |-> !inverseTrip)
        else $error("Infinite multiplier still tripped.");
    AST_IEC_RESET: assert property (idleIec |-> inverseAccum == '0)
        else $error("Accumulator kept after IEC dropout.");
endmodule
bind unbalanced_load_trip_logic ul_monitor i_ul_monitor (.clk, .rst, .tick, .blockIn, .curveType, .stage1Delay,
    .inverse_time_multiplier, .functionActive, .stage1Pickup, .stage2Pickup, .inversePickup, .stage1Trip,
    .stage2Trip, .inverseTrip, .tripOut, .storedNegSeq, .inverseAccum);
`default_nettype wire

/* tb/measure_front.sv */
`timescale 1ns/1ps
`default_nettype none
module measure_front (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] negLevel,
    input wire logic [15:0] phaseLevel,
    input wire logic [15:0] phaseCLevel,
    output logic tick,
    output logic [15:0] phaseA,
    output logic [15:0] phaseB,
    output logic [15:0] phaseC,
    output logic [15:0] negSeq
);
    logic [2:0] slot_q = 3'h0;
    logic [15:0] neg_q = 16'h0000;
    logic [15:0] ph_q = 16'h0000;
    logic [15:0] phC_q = 16'h0000;
    always_ff @(posedge clk) begin
        slot_q <= rst ? 3'h0 : slot_q + 3'h1;
        neg_q <= negLevel;
        ph_q <= phaseLevel;
        phC_q <= phaseCLevel;
    end
    assign tick = (slot_q == 3'h7);
    // Words are only valid on the tick; elsewhere they are inverted to expose a reader that ignores it.
    assign negSeq = tick ? neg_q : ~neg_q;
    assign phaseA = tick ? ph_q : ~ph_q;
    assign phaseB = tick ? ph_q : ~ph_q;
    assign phaseC = tick ? phC_q : ~phC_q;
endmodule
`default_nettype wire

/* tb/tb_unbalanced_load_trip_logic.sv */
`timescale 1ns/1ps
`default_nettype none
`include "unbalanced_load_map.svh"
module tb_unbalanced_load_trip_logic;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic blockIn = 1'b0;
    logic inverseEnable = 1'b0;
    logic diskEmulation = 1'b0;
    logic tick, functionActive, stage1Pickup, stage2Pickup, inversePickup, stage1Trip, stage2Trip, inverseTrip, tripOut;
    logic [15:0] negLevel = 16'h0000;
    logic [15:0] phaseLevel = 16'h000D;
    logic [15:0] phaseCLevel = 16'h000D;
    logic [15:0] phaseA, phaseB, phaseC, negSeq, storedNegSeq;
    logic [15:0] stage1Threshold = 16'h0100;
    logic [15:0] stage2Threshold = 16'h0200;
    logic [15:0] inverse_stage_threshold = 16'h0100;
    logic [15:0] inverse_time_multiplier = 16'h0001;
    logic [23:0] stage1Delay = 24'h00_0003;
    logic [23:0] stage2Delay = 24'h00_0002;
    logic [23:0] holdTime = 24'h00_0003;
    logic [31:0] curveTripLevel = 32'h0000_000A;
    logic [31:0] curveRate = 32'h0000_0004;
    logic [31:0] curveResetRate = 32'h0000_0001;
    logic [31:0] inverseAccum;
    unbalanced_load_pkg::curve_t curveType = unbalanced_load_pkg::CURVE_IEC;
    int badCount = 0;
    int totalChecks = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    measure_front i_measure_front (.clk, .rst, .negLevel, .phaseLevel, .phaseCLevel, .tick, .phaseA, .phaseB,
        .phaseC, .negSeq);
    unbalanced_load_trip_logic i_unbalanced_load_trip_logic (.clk, .rst, .tick, .blockIn, .phaseA, .phaseB,
        .phaseC, .negSeq, .stage1Threshold, .stage1Delay, .stage2Threshold, .stage2Delay, .holdTime,
        .inverseEnable, .curveType, .diskEmulation, .inverse_stage_threshold, .inverse_time_multiplier,
        .curveTripLevel, .curveRate, .curveResetRate, .functionActive, .stage1Pickup, .stage2Pickup,
        .inversePickup, .stage1Trip, .stage2Trip, .inverseTrip, .tripOut, .storedNegSeq, .inverseAccum);
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chkBit(input logic got, input logic exp);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    // Results are read at the falling edge, once the tick's updates and the trip output have landed.
    task automatic ticks(input int n);
        repeat (n) @(posedge clk iff tick);
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic holdReset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            badCount++;
            wrapUp();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        ticks(2);
        chkBit(functionActive, 1'b0);
        phaseLevel <= 16'h0100;
        phaseCLevel <= 16'h0100;
        negLevel <= 16'h0100;
        ticks(1);
        chkBit(functionActive, 1'b1);
        chkBit(stage1Pickup, 1'b1);
        chkBit(stage2Pickup, 1'b0);
        negLevel <= 16'h0080;
        ticks(2);
        chkBit(stage1Pickup, 1'b1);
        chkBit(stage1Trip, 1'b0);
        negLevel <= 16'h0100;
        ticks(1);
        chkBit(tripOut, 1'b1);
        chkVal(storedNegSeq, 32'h0000_0100);
        negLevel <= 16'h0080;
        ticks(2);
        chkBit(stage1Pickup, 1'b1);
        // The hold counts like the delay: it ends three ticks after the first tick below threshold.
        ticks(1);
        chkBit(stage1Pickup, 1'b1);
        ticks(1);
        chkBit(stage1Pickup, 1'b0);
        chkBit(tripOut, 1'b0);
        negLevel <= 16'h0200;
        ticks(2);
        chkBit(stage2Pickup, 1'b1);
        chkBit(stage2Trip, 1'b0);
        ticks(1);
        chkBit(stage2Trip, 1'b1);
        chkBit(stage1Trip, 1'b0);
        @(posedge clk);
        blockIn <= 1'b1;
        repeat (6) @(negedge clk);
        chkBit(stage2Pickup, 1'b0);
        chkBit(tripOut, 1'b0);
        chkVal(storedNegSeq, 32'h0000_0000);
        @(posedge clk);
        blockIn <= 1'b0;
        ticks(1);
        chkBit(stage1Pickup, 1'b1);
        phaseCLevel <= 16'h0A00;
        ticks(2);
        chkBit(functionActive, 1'b0);
        chkBit(stage1Pickup, 1'b0);
        holdReset();
        phaseCLevel <= 16'h0100;
        inverseEnable <= 1'b1;
        stage1Delay <= `UL_INF_TIME;
        negLevel <= 16'h0118;
        rst <= 1'b0;
        ticks(1);
        chkBit(inversePickup, 1'b0);
        chkBit(stage1Pickup, 1'b1);
        negLevel <= 16'h0120;
        ticks(2);
        chkBit(inversePickup, 1'b1);
        chkBit(inverseTrip, 1'b0);
        ticks(1);
        chkBit(inverseTrip, 1'b1);
        chkBit(stage1Trip, 1'b0);
        negLevel <= 16'h00F0;
        ticks(1);
        chkBit(inversePickup, 1'b0);
        chkVal(inverseAccum, 32'h0000_0000);
        holdReset();
        curveType <= unbalanced_load_pkg::CURVE_ANSI;
        diskEmulation <= 1'b1;
        negLevel <= 16'h0120;
        rst <= 1'b0;
        ticks(2);
        chkVal(inverseAccum, 32'h0000_0008);
        negLevel <= 16'h00EC;
        ticks(2);
        chkBit(inversePickup, 1'b0);
        chkVal(inverseAccum, 32'h0000_0008);
        negLevel <= 16'h0080;
        ticks(2);
        chkVal(inverseAccum, 32'h0000_0006);
        negLevel <= 16'h0120;
        ticks(1);
        chkBit(inverseTrip, 1'b1);
        diskEmulation <= 1'b0;
        negLevel <= 16'h0080;
        ticks(1);
        chkVal(inverseAccum, 32'h0000_0000);
        holdReset();
        inverse_time_multiplier <= `UL_INF_MULT;
        stage2Threshold <= `UL_INF_CUR;
        curveRate <= 32'h0000_0005;
        // Full scale would meet an all-ones threshold, so only the infinity decode can hold stage two off.
        negLevel <= 16'hFFFF;
        rst <= 1'b0;
        ticks(4);
        chkBit(inversePickup, 1'b1);
        chkBit(inverseTrip, 1'b0);
        chkBit(stage2Pickup, 1'b0);
        inverse_stage_threshold <= `UL_INF_CUR;
        ticks(1);
        chkBit(inversePickup, 1'b0);
        wrapUp();
    end
endmodule
`default_nettype wire
